// [hdl/agc_cs_map.vh]
// register offsets, field positions, reset values, write mask and codes for the gain limit / carrier sense block
`ifndef AGC_CS_MAP_VH
`define AGC_CS_MAP_VH
`define GAIN_LIMIT_OFFSET 6'h1B
`define SENSE_ORDER_OFFSET 6'h1C
`define GAIN_LIMIT_RESET 8'h03
`define SENSE_ORDER_RESET 8'h40
`define SENSE_ORDER_WMASK 8'h7F
`define TARGET_CODE_RESET 3'h3
`define TARGET_DB_RESET 8'h21
`define DGCAP_HI 7
`define DGCAP_LO 6
`define FECAP_HI 5
`define FECAP_LO 3
`define TARGET_HI 2
`define TARGET_LO 0
`define ORDER_BIT 6
`define REL_HI 5
`define REL_LO 4
`define ABS_HI 3
`define ABS_LO 0
`define ABS_DISABLE 4'h8
`define ABS_DISABLE_MAX 4'h8
`define DG_TOP_STEP 3'h7
`endif

// [hdl/agc_limits_carrier_sense_cfg.v]
// gain limit registers, gain step clamping and carrier sense decision
`timescale 1ns/10ps
`include "agc_cs_map.vh"

// Contract
// - digital gain cap excludes top 0-3 steps
// - front-end cap lowers combined amplifier ceiling
// - amplitude target code selects 24..42 dB
// - order bit picks which amplifier drops first
// - relative sense off or 6/10/14 dB rise
// - absolute threshold signed dB around target
// - code 1000 disables absolute sense
// - compare with gain reduction added back
module agc_limits_carrier_sense_cfg (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // register port
  input wire [5:0] reg_addr_in,
  input wire reg_write_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  // gain controller requests
  input wire [2:0] digital_gain_req_in,
  input wire [2:0] front_gain_req_in,
  input wire reduce_gain_in,
  // measurements, dB
  input wire [7:0] filter_amplitude_in,
  input wire [7:0] gain_reduction_in,
  input wire [7:0] rssi_rise_in,
  // applied gains and status
  output reg [2:0] digital_gain_out,
  output reg [2:0] front_gain_cap_out,
  output reg [2:0] target_code_out,
  output reg reduce_first_stage_out,
  output reg reduce_second_stage_out,
  output reg carrier_sense_out
);
  reg [7:0] gain_limit;
  reg [7:0] sense_order;
  reg [7:0] next_gain_limit;
  reg [7:0] next_sense_order;
  reg [7:0] next_rdata;
  reg [2:0] digital_cap;
  reg [2:0] next_digital_gain;
  reg [1:0] second_stage_level;
  reg [7:0] abs_level;
  reg abs_on;
  reg abs_ok;
  reg rel_on;
  reg rel_ok;
  reg next_reduce_first;
  reg next_reduce_second;
  reg next_sense;
  wire [7:0] target_db;
  wire [7:0] rel_db;
  wire [3:0] abs_code;
  wire [1:0] rel_code;
  wire [2:0] target_code;
  wire [2:0] front_cap;
  wire [1:0] dg_cap_code;
  wire hit_gain_limit;
  wire hit_sense_order;
  wire [8:0] unreduced;
  wire [8:0] abs_thr;

  // true when the register port addresses this offset
  function addr_hit;
    input [5:0] addr;
    input [5:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // widen a dB level to the compare width
  function [8:0] widen_db;
    input [7:0] level;
    begin
      widen_db = {1'b0, level};
    end
  endfunction

  // sign-extend the signed threshold offset
  function [8:0] sext_offset;
    input [3:0] code;
    begin
      sext_offset = {{5{code[3]}}, code};
    end
  endfunction

  // smaller of request and ceiling
  function [2:0] clamp_step;
    input [2:0] req;
    input [2:0] ceiling;
    begin
      if (req > ceiling)
        clamp_step = ceiling;
      else
        clamp_step = req;
    end
  endfunction

  // register fields and address decode
  assign abs_code = sense_order[`ABS_HI:`ABS_LO];
  assign rel_code = sense_order[`REL_HI:`REL_LO];
  assign target_code = gain_limit[`TARGET_HI:`TARGET_LO];
  assign front_cap = gain_limit[`FECAP_HI:`FECAP_LO];
  assign dg_cap_code = gain_limit[`DGCAP_HI:`DGCAP_LO];
  assign hit_gain_limit = addr_hit(reg_addr_in, `GAIN_LIMIT_OFFSET);
  assign hit_sense_order = addr_hit(reg_addr_in, `SENSE_ORDER_OFFSET);

  // register writes, unmapped offsets ignored
  always @* begin
    next_gain_limit = gain_limit;
    if (reg_write_in && hit_gain_limit)
      next_gain_limit = reg_wdata_in;
  end

  // spare bit 7 never takes a write
  always @* begin
    next_sense_order = sense_order;
    if (reg_write_in && hit_sense_order)
      next_sense_order = reg_wdata_in & `SENSE_ORDER_WMASK;
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gain_limit <= `GAIN_LIMIT_RESET;
    end else begin
      gain_limit <= next_gain_limit;
    end
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sense_order <= `SENSE_ORDER_RESET;
    end else begin
      sense_order <= next_sense_order;
    end
  end

  // register reads, unmapped read as zero
  always @* begin
    if (hit_gain_limit)
      next_rdata = gain_limit;
    else if (hit_sense_order)
      next_rdata = sense_order;
    else
      next_rdata = 8'h00;
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      reg_rdata_out <= 8'h00;
    else
      reg_rdata_out <= next_rdata;
  end

  sense_threshold_lut u_lut (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .target_code_in(target_code),
    .rel_code_in(rel_code),
    .target_db_out(target_db),
    .rel_db_out(rel_db)
  );

  // highest usable digital step
  always @* begin
    digital_cap = `DG_TOP_STEP - {1'b0, dg_cap_code};
    next_digital_gain = clamp_step(digital_gain_req_in, digital_cap);
  end

  // threshold around target, sign-extended
  assign abs_thr = widen_db(target_db) + sext_offset(abs_code);
  // level with gain reduction added back
  assign unreduced = widen_db(filter_amplitude_in) + widen_db(gain_reduction_in);

  always @* begin
    abs_on = (abs_code != `ABS_DISABLE);
    abs_level = abs_thr[7:0];
    abs_ok = (unreduced >= widen_db(abs_level));
    rel_on = (rel_code != 2'h0);
    rel_ok = (rssi_rise_in >= rel_db);
    next_sense = (abs_on | rel_on) & (~abs_on | abs_ok) & (~rel_on | rel_ok);
  end

  // second stage goes first when order bit is 0
  always @* begin
    second_stage_level = sense_order[`ORDER_BIT] ? 2'h1 : 2'h2;
    next_reduce_first = reduce_gain_in & (second_stage_level == 2'h1);
    next_reduce_second = reduce_gain_in & (second_stage_level == 2'h2);
  end

  // applied gain limits
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      digital_gain_out <= 3'h0;
      front_gain_cap_out <= 3'h0;
      target_code_out <= `TARGET_CODE_RESET;
    end else begin
      digital_gain_out <= next_digital_gain;
      front_gain_cap_out <= front_cap;
      target_code_out <= target_code;
    end
  end

  // amplifier reduction strobes
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reduce_first_stage_out <= 1'b0;
      reduce_second_stage_out <= 1'b0;
    end else begin
      reduce_first_stage_out <= next_reduce_first;
      reduce_second_stage_out <= next_reduce_second;
    end
  end

  // carrier sense flag
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      carrier_sense_out <= 1'b0;
    else
      carrier_sense_out <= next_sense;
  end
endmodule

// [hdl/sense_threshold_lut.v]
// registered lookup of amplitude target and relative step in dB
`timescale 1ns/10ps
`include "agc_cs_map.vh"
module sense_threshold_lut (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // codes
  input wire [2:0] target_code_in,
  input wire [1:0] rel_code_in,
  // looked-up levels
  output reg [7:0] target_db_out,
  output reg [7:0] rel_db_out
);
  function [7:0] target_db;
    input [2:0] code;
    begin
      case (code)
        3'h0: target_db = 8'h18;
        3'h1: target_db = 8'h1B;
        3'h2: target_db = 8'h1E;
        3'h3: target_db = 8'h21;
        3'h4: target_db = 8'h24;
        3'h5: target_db = 8'h26;
        3'h6: target_db = 8'h28;
        default: target_db = 8'h2A;
      endcase
    end
  endfunction

  function [7:0] rel_db;
    input [1:0] code;
    begin
      case (code)
        2'h1: rel_db = 8'h06;
        2'h2: rel_db = 8'h0A;
        2'h3: rel_db = 8'h0E;
        default: rel_db = 8'h00;
      endcase
    end
  endfunction

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      target_db_out <= `TARGET_DB_RESET;
      rel_db_out <= 8'h00;
    end else begin
      target_db_out <= target_db(target_code_in);
      rel_db_out <= rel_db(rel_code_in);
    end
  end
endmodule

// [tb/agc_cs_props.sv]
// checker for the gain limit block
`timescale 1ns/10ps
module agc_cs_props (
  input wire clk_in, rstn_in, reg_write_in, reduce_gain_in,
  input wire reduce_first_stage_out, reduce_second_stage_out, carrier_sense_out,
  input wire [5:0] reg_addr_in,
  input wire [7:0] reg_wdata_in, reg_rdata_out,
  input wire [2:0] digital_gain_out, front_gain_cap_out, target_code_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire wa = reg_write_in && reg_addr_in == 6'h1B;
  wire wb = reg_write_in && reg_addr_in == 6'h1C;
  a_cap_set: assert property (wa |-> ##2 front_gain_cap_out == $past(reg_wdata_in[5:3], 2))
    else $error("cap");
  a_target_set: assert property (wa |-> ##2 target_code_out == $past(reg_wdata_in[2:0], 2))
    else $error("tgt");
  a_gain_clamp: assert property (wa && reg_wdata_in[7:6] == 2'h3 ##1 !reg_write_in |=> digital_gain_out < 3'h5)
    else $error("clamp");
  a_stage_excl: assert property (!(reduce_first_stage_out && reduce_second_stage_out)) else $error("both");
  a_first_cause: assert property (reduce_first_stage_out |-> $past(reduce_gain_in)) else $error("first");
  a_second_cause: assert property (reduce_second_stage_out |-> $past(reduce_gain_in)) else $error("second");
  a_unmapped_zero: assert property (reg_addr_in > 6'h1C |=> reg_rdata_out == 8'h00) else $error("unmapped");
  a_spare_bit: assert property (reg_addr_in == 6'h1C |=> !reg_rdata_out[7]) else $error("spare");
  a_sense_off: assert property (wb && reg_wdata_in[5:0] == 6'h08 ##1 !reg_write_in[*3] |-> !carrier_sense_out)
    else $error("sense");
endmodule
bind agc_limits_carrier_sense_cfg agc_cs_props u_props (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .reg_write_in(reg_write_in),
  .reduce_gain_in(reduce_gain_in),
  .reduce_first_stage_out(reduce_first_stage_out),
  .reduce_second_stage_out(reduce_second_stage_out),
  .carrier_sense_out(carrier_sense_out),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .digital_gain_out(digital_gain_out),
  .front_gain_cap_out(front_gain_cap_out),
  .target_code_out(target_code_out)
);

// [tb/agc_limits_carrier_sense_cfg_tb.sv]
// bench for the gain limit block
`timescale 1ns/10ps
module agc_limits_carrier_sense_cfg_tb;
  reg clk_in = 1'b0, rstn_in = 1'b0, reg_write_in = 1'b0, reduce_gain_in = 1'b0;
  reg [5:0] reg_addr_in = 6'h0;
  reg [7:0] reg_wdata_in = 8'h0, filter_amplitude_in = 8'h0, gain_reduction_in = 8'h0, rssi_rise_in = 8'h0;
  reg [2:0] digital_gain_req_in = 3'h7, front_gain_req_in = 3'h0;
  wire [7:0] reg_rdata_out;
  wire [2:0] digital_gain_out, front_gain_cap_out, target_code_out;
  wire reduce_first_stage_out, reduce_second_stage_out, carrier_sense_out;
  integer failures = 0, total_checks = 0, i;
  agc_limits_carrier_sense_cfg DUT (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in),
    .reg_write_in(reg_write_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .digital_gain_req_in(digital_gain_req_in),
    .front_gain_req_in(front_gain_req_in),
    .reduce_gain_in(reduce_gain_in),
    .filter_amplitude_in(filter_amplitude_in),
    .gain_reduction_in(gain_reduction_in),
    .rssi_rise_in(rssi_rise_in),
    .digital_gain_out(digital_gain_out),
    .front_gain_cap_out(front_gain_cap_out),
    .target_code_out(target_code_out),
    .reduce_first_stage_out(reduce_first_stage_out),
    .reduce_second_stage_out(reduce_second_stage_out),
    .carrier_sense_out(carrier_sense_out)
  );
  initial forever #2 clk_in = ~clk_in;
  task c(input [39:0] n, input [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %0s expected %h seen %h", n, e, g);
    end
  endtask
  // one access plus measurements, returns with every output settled
  task t(input w, input [5:0] a, input [7:0] d, m, x);
    @(posedge clk_in) {reg_write_in, reg_addr_in, reg_wdata_in, filter_amplitude_in, rssi_rise_in} <= {w, a, d, m, x};
    @(posedge clk_in) reg_write_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task s(input [7:0] m, x, input e);
    t(1'b0, 6'h1C, 8'h0, m, x);
    c("cs", e, carrier_sense_out);
  endtask
  task stop_test;
    $display("%0d checks %0d failures", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    t(1'b0, 6'h1B, 8'h0, 8'h0, 8'h0);
    c("reg1", 8'h03, reg_rdata_out);
    t(1'b1, 6'h2A, 8'hFF, 8'h0, 8'h0);
    c("unmap", 8'h00, reg_rdata_out);
    t(1'b0, 6'h1B, 8'h0, 8'h0, 8'h0);
    c("reg1", 8'h03, reg_rdata_out);
    t(1'b1, 6'h1C, 8'hC0, 8'h0, 8'h0);
    c("reg2", 8'h40, reg_rdata_out);
    for (i = 0; i < 8; i++) begin
      t(1'b1, 6'h1B, {i[1:0], i[2:0], i[2:0]}, 8'h0, 8'h0);
      c("dgain", 7 - i % 4, digital_gain_out);
      c("cap", i, front_gain_cap_out);
      c("tgt", i, target_code_out);
    end
    @(posedge clk_in) digital_gain_req_in <= 3'h2;
    t(1'b0, 6'h1B, 8'h0, 8'h0, 8'h0);
    c("rdgl", 8'hFF, reg_rdata_out);
    c("dglow", 8'h02, digital_gain_out);
    s(8'h2A, 8'h0, 1'b1);
    s(8'h29, 8'h0, 1'b0);
    @(posedge clk_in) gain_reduction_in <= 8'h1;
    s(8'h29, 8'h0, 1'b1);
    t(1'b1, 6'h1C, 8'h48, 8'h0, 8'h0);
    s(8'h7F, 8'h0, 1'b0);
    for (i = 1; i < 4; i++) begin
      t(1'b1, 6'h1C, {2'h1, i[1:0], 4'h8}, 8'h0, 8'h0);
      s(8'h0, 4 * i + 1, 1'b0);
      s(8'h0, 4 * i + 2, 1'b1);
    end
    t(1'b1, 6'h1C, 8'h50, 8'h0, 8'h0);
    s(8'h28, 8'h6, 1'b0);
    s(8'h29, 8'h5, 1'b0);
    s(8'h29, 8'h6, 1'b1);
    @(posedge clk_in) reduce_gain_in <= 1'b1;
    s(8'h0, 8'h0, 1'b0);
    c("first", 1, reduce_first_stage_out);
    c("secnd", 0, reduce_second_stage_out);
    t(1'b1, 6'h1C, 8'h0, 8'h0, 8'h0);
    c("secnd", 1, reduce_second_stage_out);
    c("first", 0, reduce_first_stage_out);
    stop_test;
  end
endmodule
